// file: rtl/dimc_regs.svh
/*
  Register offsets, field positions, reset values and counts for the dual
  measurement pin configuration block.
  Assumes it is included by the package and the design file only.
*/
`ifndef DIMC_REGS_SVH
`define DIMC_REGS_SVH

`define DIMC_OFS_CONFIG_TWO 8'h01
`define DIMC_OFS_CONFIG_THREE 8'h02
`define DIMC_OFS_FAN_AUTO_CONFIG_ONE 8'h05
`define DIMC_OFS_IRQ_STATUS_ONE 8'h10
`define DIMC_OFS_IRQ_STATUS_TWO 8'h11
`define DIMC_OFS_IRQ_MASK_ONE 8'h12
`define DIMC_OFS_IRQ_MASK_TWO 8'h13
`define DIMC_OFS_CHAN_ONE_LOW_LIMIT 8'h14
`define DIMC_OFS_CHAN_ONE_HIGH_LIMIT 8'h15
`define DIMC_OFS_CHAN_TWO_LOW_LIMIT 8'h16
`define DIMC_OFS_CHAN_TWO_HIGH_LIMIT 8'h17

`define DIMC_BIT_SECOND_DIODE_SEL 7
`define DIMC_BIT_TH_ONE_SEL 7
`define DIMC_BIT_TH_TWO_SEL 6
`define DIMC_BIT_LIM_ONE 6
`define DIMC_BIT_LIM_TWO 5
`define DIMC_BIT_DIODE_ONE_NC 2
`define DIMC_BIT_DIODE_TWO_NC 3
`define DIMC_BIT_TH_ONE_NC 4
`define DIMC_BIT_TH_TWO_NC 5

`define DIMC_RST_ZERO 8'h00
`define DIMC_RST_CONFIG_THREE 8'hC0
`define DIMC_RST_HIGH_LIMIT 8'hFF
`define DIMC_RST_LOW_LIMIT 8'h00

`define DIMC_AVG_COUNT 16
`define DIMC_AVG_SHIFT 4
`define DIMC_ADC_WIDTH 8
`define DIMC_ADC_FULL 8'hFF

`endif

// file: rtl/dimc_pkg.sv
/*
  Types for the dual measurement pin configuration block.
  Assumes dimc_regs.svh is on the include path.
*/
`default_nettype none
`include "dimc_regs.svh"

package dimc_pkg;

  typedef enum logic [1:0] {
    DIMC_BIAS_BASE_A = 2'b00,
    DIMC_BIAS_MULT_ONE = 2'b01,
    DIMC_BIAS_BASE_B = 2'b10,
    DIMC_BIAS_MULT_TWO = 2'b11
  } dimc_bias_e;

  typedef enum logic [1:0] {
    DIMC_MODE_THERM = 2'b00,
    DIMC_MODE_VOLT = 2'b01,
    DIMC_MODE_DIODE = 2'b10
  } dimc_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dimc_reg_req_s;

  typedef struct packed {
    logic valid;
    logic chan;
    logic is_temp;
    logic [7:0] code;
  } dimc_sample_s;

  typedef struct packed {
    logic diode_one_fault;
    logic diode_two_fault;
    logic therm_one_open;
    logic therm_two_open;
  } dimc_fault_s;

  typedef struct packed {
    logic [7:0] config_two;
    logic [7:0] config_three;
    logic [7:0] fan_auto_config_one;
    logic [7:0] irq_status_one;
    logic [7:0] irq_status_two;
    logic [7:0] irq_mask_one;
    logic [7:0] irq_mask_two;
    logic [7:0] chan_one_low_limit;
    logic [7:0] chan_one_high_limit;
    logic [7:0] chan_two_low_limit;
    logic [7:0] chan_two_high_limit;
    logic [7:0] rdata;
    logic [7:0] result_one;
    logic [7:0] result_two;
    logic [11:0] acc_one;
    logic [11:0] acc_two;
    logic [3:0] avg_cnt_one;
    logic [3:0] avg_cnt_two;
    dimc_bias_e bias_step;
    logic alert_n;
  } dimc_state_s;

endpackage

`default_nettype wire

// file: rtl/dimc_core.sv
/*
  Mode selection, limit checking, fault status and result averaging for the
  two shared measurement pins.
  Assumes the serial bus slave hands over decoded single-byte register reads
  and writes, and the analog front end delivers one 8-bit code per cycle it
  flags valid, already coded at about 8.8 mV per step and saturated at 255.
*/
`default_nettype none
`include "dimc_regs.svh"

module dimc_core #(
  parameter int AVG_COUNT = `DIMC_AVG_COUNT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire dimc_pkg::dimc_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire dimc_pkg::dimc_sample_s sample,
  input wire dimc_pkg::dimc_fault_s fault,
  input wire logic avg_enable,
  output dimc_pkg::dimc_mode_e mode_one,
  output dimc_pkg::dimc_mode_e mode_two,
  output dimc_pkg::dimc_bias_e bias_step,
  output logic [7:0] result_one,
  output logic [7:0] result_two,
  output logic alert_n
);

  dimc_pkg::dimc_state_s st;
  dimc_pkg::dimc_state_s next_st;

  function automatic logic out_of_range(input logic [7:0] code,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    out_of_range = (code < lo) || (code > hi);
  endfunction

  // Twelve bits hold sixteen full-scale codes without wrapping
  function automatic logic [11:0] acc_add(input logic [11:0] acc,
                                          input logic [7:0] code);
    acc_add = acc + {4'h0, code};
  endfunction

  function automatic dimc_pkg::dimc_mode_e pick_mode(input logic diode,
                                                    input logic therm);
    if (diode) begin
      pick_mode = dimc_pkg::DIMC_MODE_DIODE;
    end else if (therm) begin
      pick_mode = dimc_pkg::DIMC_MODE_THERM;
    end else begin
      pick_mode = dimc_pkg::DIMC_MODE_VOLT;
    end
  endfunction

  dimc_pkg::dimc_mode_e m_one;
  dimc_pkg::dimc_mode_e m_two;
  logic diode_sel;
  logic [7:0] code_one;
  logic [7:0] code_two;
  logic take_one;
  logic take_two;
  logic [11:0] sum;
  // The divide is a fixed shift of four, so AVG_COUNT must stay 16
  localparam logic [3:0] AVG_LAST = 4'(AVG_COUNT - 1);

  // Modes decode straight from the config registers, with no extra delay
  assign diode_sel = st.config_two[`DIMC_BIT_SECOND_DIODE_SEL];
  assign m_one = pick_mode(diode_sel, st.config_three[`DIMC_BIT_TH_ONE_SEL]);
  assign m_two = pick_mode(diode_sel, st.config_three[`DIMC_BIT_TH_TWO_SEL]);

  always_comb begin
    next_st = st;
    sum = 12'h000;
    code_one = st.result_one;
    code_two = st.result_two;
    take_one = 1'b0;
    take_two = 1'b0;

    // Bias sequence cycles every clock so both differences are sampled
    case (st.bias_step)
      dimc_pkg::DIMC_BIAS_BASE_A: begin
        next_st.bias_step = dimc_pkg::DIMC_BIAS_MULT_ONE;
      end
      dimc_pkg::DIMC_BIAS_MULT_ONE: begin
        next_st.bias_step = dimc_pkg::DIMC_BIAS_BASE_B;
      end
      dimc_pkg::DIMC_BIAS_BASE_B: begin
        next_st.bias_step = dimc_pkg::DIMC_BIAS_MULT_TWO;
      end
      dimc_pkg::DIMC_BIAS_MULT_TWO: begin
        next_st.bias_step = dimc_pkg::DIMC_BIAS_BASE_A;
      end
      default: begin
        next_st.bias_step = dimc_pkg::DIMC_BIAS_BASE_A;
      end
    endcase

    // Channel one result; voltages pass straight, temperatures average
    if (sample.valid && !sample.chan) begin
      if (sample.is_temp && avg_enable) begin
        sum = acc_add(st.acc_one, sample.code);
        if (st.avg_cnt_one == AVG_LAST) begin
          code_one = sum[11:4];
          take_one = 1'b1;
          next_st.acc_one = 12'h000;
          next_st.avg_cnt_one = 4'h0;
        end else begin
          next_st.acc_one = sum;
          next_st.avg_cnt_one = st.avg_cnt_one + 4'h1;
        end
      end else begin
        code_one = sample.code;
        take_one = 1'b1;
      end
    end

    // Channel two is unused while the pins carry the second diode
    if (sample.valid && sample.chan &&
        m_two != dimc_pkg::DIMC_MODE_DIODE) begin
      if (sample.is_temp && avg_enable) begin
        sum = acc_add(st.acc_two, sample.code);
        if (st.avg_cnt_two == AVG_LAST) begin
          code_two = sum[11:4];
          take_two = 1'b1;
          next_st.acc_two = 12'h000;
          next_st.avg_cnt_two = 4'h0;
        end else begin
          next_st.acc_two = sum;
          next_st.avg_cnt_two = st.avg_cnt_two + 4'h1;
        end
      end else begin
        code_two = sample.code;
        take_two = 1'b1;
      end
    end

    // Results hold until a fresh code arrives on their channel
    if (take_one) begin
      next_st.result_one = code_one;
    end
    if (take_two) begin
      next_st.result_two = code_two;
    end

    // Register writes; status bits are not writable
    if (reg_req.wr) begin
      case (reg_req.addr)
        `DIMC_OFS_CONFIG_TWO: begin
          next_st.config_two = reg_req.wdata;
        end
        `DIMC_OFS_CONFIG_THREE: begin
          next_st.config_three = reg_req.wdata;
        end
        `DIMC_OFS_FAN_AUTO_CONFIG_ONE: begin
          next_st.fan_auto_config_one = reg_req.wdata;
        end
        `DIMC_OFS_IRQ_MASK_ONE: begin
          next_st.irq_mask_one = reg_req.wdata;
        end
        `DIMC_OFS_IRQ_MASK_TWO: begin
          next_st.irq_mask_two = reg_req.wdata;
        end
        `DIMC_OFS_CHAN_ONE_LOW_LIMIT: begin
          next_st.chan_one_low_limit = reg_req.wdata;
        end
        `DIMC_OFS_CHAN_ONE_HIGH_LIMIT: begin
          next_st.chan_one_high_limit = reg_req.wdata;
        end
        `DIMC_OFS_CHAN_TWO_LOW_LIMIT: begin
          next_st.chan_two_low_limit = reg_req.wdata;
        end
        `DIMC_OFS_CHAN_TWO_HIGH_LIMIT: begin
          next_st.chan_two_high_limit = reg_req.wdata;
        end
        // Status offsets land here, so a write can never clear a flag
        default: begin
        end
      endcase
    end

    // Reading a status register clears it; a same-cycle event still lands
    if (reg_req.rd) begin
      case (reg_req.addr)
        `DIMC_OFS_CONFIG_TWO: begin
          next_st.rdata = st.config_two;
        end
        `DIMC_OFS_CONFIG_THREE: begin
          next_st.rdata = st.config_three;
        end
        `DIMC_OFS_FAN_AUTO_CONFIG_ONE: begin
          next_st.rdata = st.fan_auto_config_one;
        end
        `DIMC_OFS_IRQ_STATUS_ONE: begin
          next_st.rdata = st.irq_status_one;
          next_st.irq_status_one = 8'h00;
        end
        `DIMC_OFS_IRQ_STATUS_TWO: begin
          next_st.rdata = st.irq_status_two;
          next_st.irq_status_two = 8'h00;
        end
        `DIMC_OFS_IRQ_MASK_ONE: begin
          next_st.rdata = st.irq_mask_one;
        end
        `DIMC_OFS_IRQ_MASK_TWO: begin
          next_st.rdata = st.irq_mask_two;
        end
        `DIMC_OFS_CHAN_ONE_LOW_LIMIT: begin
          next_st.rdata = st.chan_one_low_limit;
        end
        `DIMC_OFS_CHAN_ONE_HIGH_LIMIT: begin
          next_st.rdata = st.chan_one_high_limit;
        end
        `DIMC_OFS_CHAN_TWO_LOW_LIMIT: begin
          next_st.rdata = st.chan_two_low_limit;
        end
        `DIMC_OFS_CHAN_TWO_HIGH_LIMIT: begin
          next_st.rdata = st.chan_two_high_limit;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // Limit checks on each fresh result
    if (take_one && out_of_range(code_one, st.chan_one_low_limit,
                                 st.chan_one_high_limit)) begin
      next_st.irq_status_one[`DIMC_BIT_LIM_ONE] = 1'b1;
    end
    if (take_two && out_of_range(code_two, st.chan_two_low_limit,
                                 st.chan_two_high_limit)) begin
      next_st.irq_status_one[`DIMC_BIT_LIM_TWO] = 1'b1;
    end

    // Diode one fault always flags; the other fault flags follow the active mode of each pin
    if (fault.diode_one_fault) begin
      next_st.irq_status_two[`DIMC_BIT_DIODE_ONE_NC] = 1'b1;
    end
    if (fault.diode_two_fault && diode_sel) begin
      next_st.irq_status_two[`DIMC_BIT_DIODE_TWO_NC] = 1'b1;
    end
    if (fault.therm_one_open && m_one == dimc_pkg::DIMC_MODE_THERM) begin
      next_st.irq_status_two[`DIMC_BIT_TH_ONE_NC] = 1'b1;
    end
    if (fault.therm_two_open && m_two == dimc_pkg::DIMC_MODE_THERM) begin
      next_st.irq_status_two[`DIMC_BIT_TH_TWO_NC] = 1'b1;
    end

    // Masks only gate the alert pin, never the status bits; a new mask
    // acts in the cycle it is written so alert follows it at once
    next_st.alert_n = 1'b1;
    if (|(next_st.irq_status_one & ~next_st.irq_mask_one)) begin
      next_st.alert_n = 1'b0;
    end
    if (|(next_st.irq_status_two & ~next_st.irq_mask_two)) begin
      next_st.alert_n = 1'b0;
    end

    // Reset comes last so it overrides every update above
    if (!resetn) begin
      next_st = '0;
      next_st.config_three = `DIMC_RST_CONFIG_THREE;
      next_st.chan_one_low_limit = `DIMC_RST_LOW_LIMIT;
      next_st.chan_one_high_limit = `DIMC_RST_HIGH_LIMIT;
      next_st.chan_two_low_limit = `DIMC_RST_LOW_LIMIT;
      next_st.chan_two_high_limit = `DIMC_RST_HIGH_LIMIT;
      next_st.bias_step = dimc_pkg::DIMC_BIAS_BASE_A;
      next_st.alert_n = 1'b1;
    end
  end

  // One register stage for the whole state keeps every output a flop except mode_one and mode_two, which decode from it
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign reg_rdata = st.rdata;
  assign mode_one = m_one;
  assign mode_two = m_two;
  assign bias_step = st.bias_step;
  assign result_one = st.result_one;
  assign result_two = st.result_two;
  assign alert_n = st.alert_n;

endmodule

`default_nettype wire

// file: testbench/dimc_core_chk.sv
/* Port checker for dimc_core.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module dimc_core_chk #(parameter int AVG_COUNT = 16) (
  input wire logic clk,
  input wire logic resetn,
  input wire dimc_pkg::dimc_reg_req_s reg_req,
  input wire logic [7:0] reg_rdata,
  input wire dimc_pkg::dimc_sample_s sample,
  input wire dimc_pkg::dimc_fault_s fault,
  input wire logic avg_enable,
  input wire dimc_pkg::dimc_mode_e mode_one,
  input wire dimc_pkg::dimc_mode_e mode_two,
  input wire dimc_pkg::dimc_bias_e bias_step,
  input wire logic [7:0] result_one,
  input wire logic [7:0] result_two,
  input wire logic alert_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_mode_reset: assert property (disable iff (1'b0) !resetn |=>
    mode_one == dimc_pkg::DIMC_MODE_THERM &&
    mode_two == dimc_pkg::DIMC_MODE_THERM) else $error("mode after reset");
  a_diode_wins: assert property (
    reg_req.wr && reg_req.addr == 8'h01 && reg_req.wdata[7] |=>
    mode_one == dimc_pkg::DIMC_MODE_DIODE &&
    mode_two == dimc_pkg::DIMC_MODE_DIODE) else $error("diode mode lost");
  a_therm_sel: assert property (
    reg_req.wr && reg_req.addr == 8'h02 |=>
    mode_one == dimc_pkg::DIMC_MODE_DIODE || mode_one == ($past(
    reg_req.wdata[7]) ? dimc_pkg::DIMC_MODE_THERM : dimc_pkg::DIMC_MODE_VOLT))
    else $error("channel one mode select");
  a_bias_walk: assert property (
    1'b1 |=> bias_step == 2'($past(bias_step) + 2'd1))
    else $error("bias sequence broken");
  a_volt_pass: assert property (
    sample.valid && !sample.is_temp && !sample.chan |=>
    result_one == $past(sample.code)) else $error("voltage code");
  a_result_cause: assert property (
    !$stable(result_one) |-> $past(sample.valid && !sample.chan))
    else $error("result changed unprompted");
  a_alert_cause: assert property (
    $fell(alert_n) |-> $past(sample.valid || reg_req.wr || (|fault)))
    else $error("alert without event");
  a_diode_flag: assert property (
    reg_req.rd && reg_req.addr == 8'h11 && fault.diode_one_fault &&
    $past(fault.diode_one_fault) |=> reg_rdata[2])
    else $error("diode fault flag");
endmodule
bind dimc_core dimc_core_chk #(.AVG_COUNT(AVG_COUNT)) chk_u (.clk(clk),
  .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .sample(sample), .fault(fault), .avg_enable(avg_enable),
  .mode_one(mode_one), .mode_two(mode_two), .bias_step(bias_step),
  .result_one(result_one), .result_two(result_two), .alert_n(alert_n));
`default_nettype wire

// file: testbench/dimc_sensor_model.sv
/* Sensor and converter model for the shared pins.
   Assumes the bench changes its inputs at the falling edge. */
`default_nettype none
module dimc_sensor_model (
  input wire logic clk,
  input wire logic go,
  input wire logic chan,
  input wire logic tmp,
  input wire logic [11:0] mv,
  input wire logic [3:0] flt,
  output dimc_pkg::dimc_sample_s sample,
  output dimc_pkg::dimc_fault_s fault
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last = 8'h00;
  logic [7:0] code;
  always_comb begin
    if (tmp) code = mv[7:0];
    else if (mv >= 12'd2244) code = 8'hFF;
    else code = 8'(mv * 10 / 88);
  end
  // Idle code shows the inverse of the last one, so stale reuse shows up
  always_ff @(posedge clk) if (go) last <= code;
  assign sample = '{go, chan, tmp, go ? code : ~last};
  assign fault = flt;
endmodule
`default_nettype wire

// file: testbench/dual_input_mode_config_tb.sv
/* Self-checking bench for dimc_core with a sensor and converter model.
   Assumes the checker binds itself to the design. */
`default_nettype none
module dual_input_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, avg_enable = 0, go = 0, chan = 0, tmp = 0;
  logic [11:0] mv = 12'h000;
  logic [3:0] flt = 4'h0;
  dimc_pkg::dimc_reg_req_s reg_req = '0;
  dimc_pkg::dimc_sample_s sample;
  dimc_pkg::dimc_fault_s fault;
  dimc_pkg::dimc_mode_e mode_one, mode_two;
  logic [7:0] reg_rdata, result_one, result_two, rd_v, keep;
  logic alert_n;
  int mismatches = 0, checks = 0, cycles = 0, sum, lo, code, out_of_limit_flag;
  int vs[4], codes[$];
  dimc_core dut_u (.clk(clk), .resetn(resetn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sample(sample), .fault(fault),
    .avg_enable(avg_enable), .mode_one(mode_one), .mode_two(mode_two),
    .bias_step(), .result_one(result_one), .result_two(result_two),
    .alert_n(alert_n));
  dimc_sensor_model sns_u (.clk(clk), .go(go), .chan(chan), .tmp(tmp),
    .mv(mv), .flt(flt), .sample(sample), .fault(fault));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      wrap_up;
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk) reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) reg_req <= '0;
    rd_v = reg_rdata;
  endtask
  task automatic send(input logic c, input logic t, input int v);
    @(negedge clk) begin
      go <= 1'b1;
      chan <= c;
      tmp <= t;
      mv <= 12'(v);
    end
    @(negedge clk) go <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'ha8ea));
    repeat (10) @(negedge clk);
    resetn <= 1'b1;
    rd(8'h02);
    cmp8(rd_v, 8'hC0);
    cmp8({4'h0, mode_one, mode_two}, 8'h00);
    rd(8'h30);
    cmp8(rd_v, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h02, 8'h00);
    cmp8({4'h0, mode_one, mode_two}, 8'h05);
    wr(8'h10, 8'hFF);
    rd(8'h10);
    cmp8(rd_v, 8'h00);
    for (int c = 0; c < 2; c++) begin
      lo = 16 + $urandom_range(15);
      wr(8'h14 + 8'(2 * c), 8'(lo));
      wr(8'h15 + 8'(2 * c), 8'd180);
      vs = '{50, 1690, 2300, 340 + $urandom_range(1060)};
      foreach (vs[i]) begin
        code = vs[i] >= 2244 ? 255 : vs[i] * 10 / 88;
        out_of_limit_flag = code < lo || code > 180;
        send(c[0], 1'b0, vs[i]);
        cmp8(c ? result_two : result_one, 8'(code));
        cmp8({7'h0, alert_n}, out_of_limit_flag ? 8'h00 : 8'h01);
        rd(8'h10);
        cmp8(rd_v, out_of_limit_flag ? (c ? 8'h20 : 8'h40) : 8'h00);
      end
    end
    avg_enable <= 1'b1;
    wr(8'h02, 8'hC0);
    keep = result_one;
    repeat (16) begin
      if (codes.size() == 15) cmp8(result_one, keep);
      codes.push_back($urandom_range(255));
      send(1'b0, 1'b1, codes[$]);
    end
    sum = 0;
    foreach (codes[i]) sum += codes[i];
    cmp8(result_one, 8'(sum / 16));
    wr(8'h01, 8'h80);
    wr(8'h13, 8'h30);
    wr(8'h12, 8'h20);
    cmp8({4'h0, mode_one, mode_two}, 8'h0A);
    keep = result_two;
    send(1'b1, 1'b0, 900);
    cmp8(result_two, keep);
    flt <= 4'hF;
    repeat (2) @(negedge clk);
    rd(8'h11);
    cmp8(rd_v, 8'h0C);
    wr(8'h01, 8'h00);
    wr(8'h13, 8'h0C);
    flt <= 4'h3;
    rd(8'h11);
    rd(8'h11);
    cmp8(rd_v, 8'h30);
    flt <= 4'h0;
    wrap_up;
  end
endmodule
`default_nettype wire
